// >>> asrc_pkg.sv
package asrc_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;

  // ****************************************************************
  // Timing, in ns (fast grade defaults)
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS            = 10;
  localparam int unsigned ADDR_SETUP_NS            = 20;
  localparam int unsigned WRITE_RECOVERY_NS        = 15;
  localparam int unsigned ADDR_VALID_TO_WRITE_END  = 130;
  localparam int unsigned WRITE_PULSE_NS           = 100;
  localparam int unsigned DATA_BEFORE_WRITE_END    = 50;
  localparam int unsigned DATA_AFTER_WRITE_END     = 20;
  localparam int unsigned WRITE_TO_FLOAT_TIME      = 60;
  localparam int unsigned ADDRESS_ACCESS_TIME      = 150;
  localparam int unsigned READ_CYCLE_TIME          = 150;
  localparam int unsigned DESELECT_FLOAT_NS        = 70;
  localparam int unsigned DESELECT_TO_RETENTION_TIME = 0;

  // Least times round up to whole clock cycles
  function automatic int unsigned asrc_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CNT_W = 8;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_s;

  typedef struct packed {
    logic              primary_select_n;
    logic              secondary_select_n;
    logic              write_n;
    logic [ADDR_W-1:0] addr;
  } asrc_pins_s;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WSETUP  = 3'b001,
    ST_WPULSE  = 3'b010,
    ST_WHOLD   = 3'b011,
    ST_RACCESS = 3'b100,
    ST_RETAIN  = 3'b101,
    ST_RECOVER = 3'b110
  } asrc_state_e;

endpackage

// >>> asrc_ctrl.sv
`timescale 1ns/1ps
module asrc_ctrl #(
  parameter int unsigned ADDR_W = asrc_pkg::ADDR_W,
  parameter int unsigned DATA_W = asrc_pkg::DATA_W
) (
  input  wire logic                 CLK,        // 100 MHz clock
  input  wire logic                 RST,        // Sync reset, active high
  input  wire logic                 REQ_VALID,  // Request offered
  output logic                      REQ_READY,  // Request taken
  input  wire asrc_pkg::asrc_req_s  REQ,        // Op, address, write data
  output logic                      RSP_VALID,  // One-cycle completion
  output logic [DATA_W-1:0]         RSP_RDATA,  // Read data
  input  wire logic                 RETAIN_REQ, // Hold deselected, level
  output logic                      RETAIN_ACK, // Safe to drop supply
  output asrc_pkg::asrc_pins_s      MEM_PINS,   // Selects, strobe, addr
  input  wire logic [DATA_W-1:0]    MEM_DQ_I,   // Data pins in
  output logic [DATA_W-1:0]         MEM_DQ_O,   // Data pins out
  output logic                      MEM_DQ_OE   // Data pins enable
);
  import asrc_pkg::*;

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  // Setup covers both the address set-up and address-valid-minus-pulse
  localparam int unsigned SETUP_A = asrc_cyc(ADDR_SETUP_NS);
  localparam int unsigned SETUP_B =
    asrc_cyc(ADDR_VALID_TO_WRITE_END) - asrc_cyc(WRITE_PULSE_NS);
  localparam logic [CNT_W-1:0] WSETUP_CYC = CNT_W'(
    (SETUP_A > SETUP_B) ? SETUP_A : SETUP_B);
  localparam logic [CNT_W-1:0] WPULSE_CYC = CNT_W'(
    (asrc_cyc(WRITE_PULSE_NS) > asrc_cyc(DATA_BEFORE_WRITE_END))
      ? asrc_cyc(WRITE_PULSE_NS)
      : asrc_cyc(DATA_BEFORE_WRITE_END));
  localparam logic [CNT_W-1:0] WHOLD_CYC = CNT_W'(
    (asrc_cyc(WRITE_RECOVERY_NS) > asrc_cyc(DATA_AFTER_WRITE_END))
      ? asrc_cyc(WRITE_RECOVERY_NS)
      : asrc_cyc(DATA_AFTER_WRITE_END));
  // Pin register, one clean sample past access, then two sync stages;
  // sampling on the edge the data settles would race the memory
  localparam int unsigned RD_EXTRA_CYC = 4;
  localparam logic [CNT_W-1:0] RACC_CYC = CNT_W'(
    asrc_cyc(ADDRESS_ACCESS_TIME) + RD_EXTRA_CYC);
  localparam logic [CNT_W-1:0] FLOAT_CYC =
    CNT_W'(asrc_cyc(DESELECT_FLOAT_NS));
  localparam logic [CNT_W-1:0] RECOVER_CYC =
    CNT_W'(asrc_cyc(READ_CYCLE_TIME));
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  asrc_state_e        state_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   float_q;
  logic               is_write_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [DATA_W-1:0]  wdata_q;
  logic [DATA_W-1:0]  dq_meta_q;
  logic [DATA_W-1:0]  dq_sync_q;
  logic               last_cyc;

  assign last_cyc  = (cnt_q == CNT_ONE);
  // Wait for the memory to float after any read before writing
  assign REQ_READY = (state_q == ST_IDLE) && !RETAIN_REQ &&
                     (!REQ.write || float_q == '0);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end
    else
    begin
      if (cnt_q != '0)
        cnt_q <= cnt_q - CNT_ONE;
      unique case (state_q)
        ST_IDLE:
        begin
          if (RETAIN_REQ)
            state_q <= ST_RETAIN;
          else if (REQ_VALID && REQ_READY)
          begin
            state_q <= REQ.write ? ST_WSETUP : ST_RACCESS;
            cnt_q   <= REQ.write ? WSETUP_CYC : RACC_CYC;
          end
        end
        ST_WSETUP:
          if (last_cyc)
          begin
            state_q <= ST_WPULSE;
            cnt_q   <= WPULSE_CYC;
          end
        ST_WPULSE:
          if (last_cyc)
          begin
            state_q <= ST_WHOLD;
            cnt_q   <= WHOLD_CYC;
          end
        ST_WHOLD:
          if (last_cyc)
            state_q <= ST_IDLE;
        ST_RACCESS:
          if (last_cyc)
            state_q <= ST_IDLE;
        ST_RETAIN:
          if (!RETAIN_REQ)
          begin
            state_q <= ST_RECOVER;
            cnt_q   <= RECOVER_CYC;
          end
        ST_RECOVER:
          if (last_cyc)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Captured request
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      is_write_q <= 1'b0;
      addr_q     <= '0;
      wdata_q    <= '0;
    end
    else if (REQ_VALID && REQ_READY)
    begin
      is_write_q <= REQ.write;
      addr_q     <= REQ.addr;
      wdata_q    <= REQ.wdata;
    end
  end

  // ****************************************************************
  // Float guard after reads
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
      float_q <= '0;
    else if (state_q == ST_RACCESS)
      float_q <= FLOAT_CYC;
    else if (float_q != '0)
      float_q <= float_q - CNT_ONE;
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      MEM_PINS.primary_select_n   <= 1'b1;
      MEM_PINS.secondary_select_n <= 1'b1;
      MEM_PINS.write_n            <= 1'b1;
      MEM_PINS.addr               <= '0;
      MEM_DQ_O                    <= '0;
      MEM_DQ_OE                   <= 1'b0;
    end
    else
    begin
      // Selects follow the strobe so the memory never drives on writes
      MEM_PINS.primary_select_n   <=
        !(state_q == ST_RACCESS || state_q == ST_WPULSE);
      MEM_PINS.secondary_select_n <=
        !(state_q == ST_RACCESS || state_q == ST_WPULSE);
      MEM_PINS.write_n            <= !(state_q == ST_WPULSE);
      if (state_q == ST_WSETUP || state_q == ST_RACCESS)
        MEM_PINS.addr             <= addr_q;
      MEM_DQ_O                    <= wdata_q;
      MEM_DQ_OE                   <= (state_q == ST_WSETUP) ||
                                     (state_q == ST_WPULSE) ||
                                     (state_q == ST_WHOLD);
    end
  end

  // ****************************************************************
  // Read return
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      dq_meta_q <= '0;
      dq_sync_q <= '0;
    end
    else
    begin
      dq_meta_q <= MEM_DQ_I;
      dq_sync_q <= dq_meta_q;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      RSP_VALID  <= 1'b0;
      RSP_RDATA  <= '0;
      RETAIN_ACK <= 1'b0;
    end
    else
    begin
      RSP_VALID  <= last_cyc &&
                    (state_q == ST_RACCESS || state_q == ST_WHOLD);
      if (last_cyc && state_q == ST_RACCESS)
        RSP_RDATA <= dq_sync_q;
      RETAIN_ACK <= (state_q == ST_RETAIN) && RETAIN_REQ;
    end
  end

endmodule

// >>> asrc_mem_model.sv
`timescale 1ns/1ps
module asrc_mem_model #(
  parameter int ACC_NS = 150
) (
  input  wire asrc_pkg::asrc_pins_s pins,  // Selects, strobe, address
  input  wire logic [7:0]           dq,    // Resolved data wire
  output logic [7:0]                dq_o,  // Read data out
  output logic                      dq_oe  // High while driving
);
  import asrc_pkg::*;
  logic [7:0] mem [2048];
  logic       sel;
  logic       oe_late;
  assign sel = !pins.primary_select_n && !pins.secondary_select_n;
  always @* if (sel && !pins.write_n) mem[pins.addr] = dq;
  // Slow turn-on, instant turn-off: mildest case for contention
  assign #10 oe_late = sel && pins.write_n;
  assign dq_oe = oe_late && sel && pins.write_n;
  assign #(ACC_NS) dq_o = mem[pins.addr];
endmodule

// >>> asrc_ctrl_props.sv
`timescale 1ns/1ps
module asrc_ctrl_props (
  input wire logic                 CLK,        // Clock
  input wire logic                 RST,        // Reset
  input wire logic                 REQ_VALID,  // Offer
  input wire logic                 REQ_READY,  // Take
  input wire asrc_pkg::asrc_req_s  REQ,        // Payload
  input wire logic                 RSP_VALID,  // Done
  input wire logic                 RETAIN_ACK, // Retention
  input wire asrc_pkg::asrc_pins_s MEM_PINS,   // Pins
  input wire logic [7:0]           MEM_DQ_O,   // Data out
  input wire logic                 MEM_DQ_OE   // Data enable
);
  logic w;
  logic sel;
  assign w = MEM_PINS.write_n;
  assign sel = !MEM_PINS.primary_select_n && !MEM_PINS.secondary_select_n;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_take(bit wr);
    REQ_VALID && REQ_READY && REQ.write == wr;
  endsequence
  sequence s_fall;
    $fell(w);
  endsequence
  sequence s_rise;
    $rose(w);
  endsequence
  a_write_answer: assert property (s_take(1) |-> ##16 RSP_VALID)
    else $error("write completion late");
  a_read_answer: assert property (s_take(0) |-> ##20 RSP_VALID)
    else $error("read completion late");
  a_read_select: assert property
    (s_take(0) |=> ##1 (sel && w && !MEM_DQ_OE)[*8])
    else $error("read not selected");
  a_addr_setup: assert property (s_fall |-> sel &&
    $stable(MEM_PINS.addr) && $past(MEM_PINS.addr, 2) == MEM_PINS.addr)
    else $error("address setup short");
  a_pulse_width: assert property (s_fall |-> (!w)[*8] ##1 (!w)[*2])
    else $error("write pulse short");
  a_addr_recover: assert property (s_rise |->
    $past(MEM_PINS.addr, 13) == MEM_PINS.addr ##1 $stable(MEM_PINS.addr))
    else $error("address moved near write end");
  a_data_setup: assert property (s_rise |-> MEM_DQ_OE &&
    $past(MEM_DQ_OE, 5) && $past(MEM_DQ_O, 5) == MEM_DQ_O)
    else $error("write data setup short");
  a_data_hold: assert property
    (s_rise |-> (MEM_DQ_OE && $stable(MEM_DQ_O))[*2])
    else $error("write data hold short");
  a_retain_quiet: assert property (RETAIN_ACK |->
    MEM_PINS.primary_select_n && MEM_PINS.secondary_select_n)
    else $error("selected during retention");
endmodule
bind asrc_ctrl asrc_ctrl_props i_asrc_ctrl_props (.CLK, .RST, .REQ_VALID,
  .REQ_READY, .REQ, .RSP_VALID, .RETAIN_ACK, .MEM_PINS, .MEM_DQ_O,
  .MEM_DQ_OE);

// >>> async_static_ram_2kx8_test.sv
`timescale 1ns/1ps
module async_static_ram_2kx8_test;
  import asrc_pkg::*;
  logic       clk, rst, req_valid, req_ready, rsp_valid;
  logic       retain_req, retain_ack, mem_oe, dq_oe;
  asrc_req_s  req;
  asrc_pins_s pins;
  logic [7:0] rdata, dq, dq_o, mem_o;
  logic [7:0] last_q = 8'h00;
  logic [7:0] shadow [2048];
  int         bad_count, checks_done, n;
  asrc_ctrl i_asrc_ctrl (.CLK(clk), .RST(rst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ(req), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rdata), .RETAIN_REQ(retain_req), .RETAIN_ACK(retain_ack),
    .MEM_PINS(pins), .MEM_DQ_I(dq), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe));
  asrc_mem_model i_asrc_mem_model (.pins(pins), .dq(dq), .dq_o(mem_o),
    .dq_oe(mem_oe));
  // Undriven wire shows the inverse, not a stale match
  assign dq = dq_oe ? dq_o : mem_oe ? mem_o : ~last_q;
  always @(posedge clk) if (dq_oe || mem_oe) last_q <= dq;
  always @(negedge clk)
    if (dq_oe === 1'b1 && mem_oe === 1'b1) check(0, 1);

  task automatic check(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // 0 ready, 1 response, 2 retention acknowledge
  function automatic logic pick(input int which);
    return (which == 0) ? req_ready :
           (which == 1) ? rsp_valid : retain_ack;
  endfunction
  task automatic wait_sig(input int which);
    n = 0;
    while (pick(which) !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 60)
      begin
        check(0, 1);
        stop_test();
      end
    end
  endtask
  task automatic op(input logic wr, input logic [10:0] a,
                    input logic [7:0] d);
    req = '{wr, a, d};
    req_valid = 1;
    // Let ready settle on the new payload before looking at it
    #1;
    wait_sig(0);
    @(negedge clk);
    req_valid = 0;
    wait_sig(1);
    if (!wr) check(rdata, shadow[a]);
    else shadow[a] = d;
    @(negedge clk);
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    check(pins.primary_select_n & pins.secondary_select_n, 1);
    check({pins.write_n, dq_oe}, 2'b10);
  endtask
  task automatic t_data;
    logic [10:0] a [3] = '{11'h000, 11'h7FF, 11'h555};
    for (int i = 0; i < 3; i++) op(1, a[i], 8'h5A ^ a[i][7:0]);
    for (int i = 2; i >= 0; i--) op(0, a[i], 8'h00);
  endtask
  task automatic t_guard;
    op(0, 11'h7FF, 8'h00);
    req = '{1'b1, 11'h001, 8'hC3};
    req_valid = 1;
    #1 check(req_ready, 0);
    op(1, 11'h001, 8'hC3);
    op(0, 11'h001, 8'h00);
  endtask
  task automatic t_retain;
    int c;
    retain_req = 1;
    wait_sig(2);
    check(pins.primary_select_n & pins.secondary_select_n, 1);
    check(req_ready, 0);
    retain_req = 0;
    c = 0;
    while (req_ready !== 1'b1 && c < 40)
    begin
      @(negedge clk);
      c++;
    end
    check(c >= 15 && c < 40, 1);
    op(0, 11'h555, 8'h00);
  endtask

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rst = 1;
    req_valid = 0;
    retain_req = 0;
    req = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(negedge clk);
    rst = 0;
    t_reset();
    t_data();
    t_guard();
    t_retain();
    stop_test();
  end
endmodule
